// File: opsr_pkg.sv
// Package: register selectors, bit positions, reset values and commands for operation status reporting
package opsr_pkg;

  localparam int unsigned OPSR_W = 16;

  // Register selectors (no bus offsets are printed, so these are command selectors)
  localparam logic [1:0] OPSR_SEL_OPER  = 2'h0;
  localparam logic [1:0] OPSR_SEL_SHUT  = 2'h1;
  localparam logic [1:0] OPSR_SEL_PROT  = 2'h2;
  localparam logic [1:0] OPSR_SEL_SHARE = 2'h3;

  // Operation status bit positions
  localparam int unsigned OPER_CAL_BIT   = 0;
  localparam int unsigned OPER_SHUT_BIT  = 9;
  localparam int unsigned OPER_LOCK_BIT  = 10;
  localparam int unsigned OPER_SHARE_BIT = 11;
  localparam int unsigned OPER_CV_BIT    = 12;
  localparam int unsigned OPER_CC_BIT    = 13;
  localparam int unsigned OPER_PROG_BIT  = 14;

  // Output-off bit positions
  localparam int unsigned SHUT_PROT_BIT  = 0;
  localparam int unsigned SHUT_LOOP_BIT  = 1;
  localparam int unsigned SHUT_EXT_BIT   = 3;

  // Protection-trip bit positions
  localparam int unsigned PROT_OV_BIT    = 0;
  localparam int unsigned PROT_UV_BIT    = 1;
  localparam int unsigned PROT_OC_BIT    = 2;
  localparam int unsigned PROT_MAINS_BIT = 4;
  localparam int unsigned PROT_OT_BIT    = 5;
  localparam int unsigned PROT_FOLD_BIT  = 7;
  localparam int unsigned PROT_FAN_BIT   = 8;

  // Load-share bit positions
  localparam int unsigned SHARE_MST_BIT  = 0;
  localparam int unsigned SHARE_FOL_BIT  = 1;

  // Implemented-bit masks; other bits read zero in condition and event
  localparam logic [15:0] OPER_IMPL_MASK  = 16'h7E01;
  localparam logic [15:0] SHUT_IMPL_MASK  = 16'h000B;
  localparam logic [15:0] PROT_IMPL_MASK  = 16'h01B7;
  localparam logic [15:0] SHARE_IMPL_MASK = 16'h0003;

  // Reset values: positive filter all ones, negative filter and enable zero
  localparam logic [15:0] OPSR_PTR_RST   = 16'hFFFF;
  localparam logic [15:0] OPSR_NTR_RST   = 16'h0000;
  localparam logic [15:0] OPSR_ENA_RST   = 16'h0000;

  localparam int unsigned STD_EVT_OPC_BIT = 0;

  // Decimal response: five digits for a 16-bit value
  localparam int unsigned OPSR_DIGITS    = 5;

  typedef enum logic [3:0] {
    OPSR_CMD_NOP,
    OPSR_CMD_Q_EVENT,
    OPSR_CMD_Q_COND,
    OPSR_CMD_Q_ENABLE,
    OPSR_CMD_Q_PTR,
    OPSR_CMD_Q_NTR,
    OPSR_CMD_W_ENABLE,
    OPSR_CMD_W_PTR,
    OPSR_CMD_W_NTR,
    OPSR_CMD_OPC,
    OPSR_CMD_OPC_Q,
    OPSR_CMD_WAI
  } opsr_cmd_e;

endpackage : opsr_pkg

// File: opsr_reg.sv
// One condition / transition-filter / event / enable status register
`timescale 1ns/10ps
module opsr_reg
  import opsr_pkg::*;
#(
  parameter int unsigned     W    = 16,
  parameter logic [W-1:0]    IMPL = '1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] cond_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         wr_enable_i,
  input  wire logic         wr_ptr_i,
  input  wire logic         wr_ntr_i,
  input  wire logic         evt_read_i,
  output logic      [W-1:0] cond_o,
  output logic      [W-1:0] event_o,
  output logic      [W-1:0] enable_o,
  output logic      [W-1:0] ptr_o,
  output logic      [W-1:0] ntr_o,
  output logic              summary_o
);

  logic [W-1:0] cond_q;
  logic [W-1:0] next_cond_q;
  logic [W-1:0] next_event;
  logic [W-1:0] next_enable;
  logic [W-1:0] next_ptr;
  logic [W-1:0] next_ntr;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  always_comb begin
    next_cond_q = cond_i & IMPL;
    rise        = next_cond_q & ~cond_q;
    fall        = ~next_cond_q & cond_q;
    // New edges win over the read-clear so no event is lost
    next_event  = ((evt_read_i ? '0 : event_o) | (rise & ptr_o) | (fall & ntr_o)) & IMPL;
    next_enable = wr_enable_i ? wr_data_i : enable_o;
    next_ptr    = wr_ptr_i ? wr_data_i : ptr_o;
    next_ntr    = wr_ntr_i ? wr_data_i : ntr_o;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cond_q   <= '0;
      event_o  <= '0;
      enable_o <= W'(OPSR_ENA_RST);
      ptr_o    <= W'(OPSR_PTR_RST);
      ntr_o    <= W'(OPSR_NTR_RST);
    end else begin
      cond_q   <= next_cond_q;
      event_o  <= next_event;
      enable_o <= next_enable;
      ptr_o    <= next_ptr;
      ntr_o    <= next_ntr;
    end
  end

  assign cond_o    = cond_q;
  assign summary_o = |(event_o & enable_o);

  a_event_rise_latch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!evt_read_i && |(next_cond_q & ~cond_q & ptr_o)) |=> |event_o)
    else $error("rising filtered condition did not latch an event");

  a_unused_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ((event_o | cond_o) & ~IMPL) == '0)
    else $error("unimplemented status bit read as one");

endmodule : opsr_reg

// File: opsr_dec.sv
// Binary to five-digit decimal converter, one digit per clock
`timescale 1ns/10ps
module opsr_dec
  import opsr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] value_i,
  output logic             busy_o,
  output logic             done_o,
  output logic      [19:0] bcd_o
);

  logic [15:0] rem;
  logic [15:0] next_rem;
  logic [2:0]  idx;
  logic [2:0]  next_idx;
  logic [19:0] next_bcd;
  logic        next_busy;
  logic        next_done;

  function automatic logic [15:0] opsr_pow10(input logic [2:0] i);
    unique case (i)
      3'h0:    opsr_pow10 = 16'h2710;
      3'h1:    opsr_pow10 = 16'h03E8;
      3'h2:    opsr_pow10 = 16'h0064;
      3'h3:    opsr_pow10 = 16'h000A;
      default: opsr_pow10 = 16'h0001;
    endcase
  endfunction : opsr_pow10

  always_comb begin
    logic [3:0] digit;
    digit     = 4'h0;
    next_rem  = rem;
    next_idx  = idx;
    next_bcd  = bcd_o;
    next_busy = busy_o;
    next_done = 1'b0;
    if (start_i && !busy_o) begin
      next_rem  = value_i;
      next_idx  = 3'h0;
      next_bcd  = 20'h00000;
      next_busy = 1'b1;
    end else if (busy_o) begin
      digit    = 4'(rem / opsr_pow10(idx));
      next_rem = 16'(rem - 16'(digit) * opsr_pow10(idx));
      next_bcd = {bcd_o[15:0], digit};
      next_idx = 3'(idx + 3'h1);
      if (idx == 3'(OPSR_DIGITS - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rem    <= 16'h0000;
      idx    <= 3'h0;
      bcd_o  <= 20'h00000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      rem    <= next_rem;
      idx    <= next_idx;
      bcd_o  <= next_bcd;
      busy_o <= next_busy;
      done_o <= next_done;
    end
  end

  a_dec_length: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (start_i && !busy_o) |=> busy_o [*5] ##1 done_o)
    else $error("decimal conversion did not take five digit cycles");

endmodule : opsr_dec

// File: opsr_top.sv
// Operation status register tree with command interface and completion handling
// Function
// - Operation-complete command sets event bit 0 once nothing is pending.
// - Wait-to-continue stalls later commands until no operation is pending.
// - Each status register is 16 bits with condition, filters, event, enable, summary.
// - Summary bit is the OR of enabled events, fed to the parent.
// - Operation bit 0 shows calibration mode.
// - Operation bit 9 carries the output-off summary.
// - Operation bit 11 carries the load-share summary.
// - Operation bit 12 is constant-voltage mode, bit 13 constant-current mode.
// - Operation bit 14 shows a sequence program running.
// - Output-off causes may be active together, each independent.
// - Output-off bit 0 carries the protection-trip summary.
// - Output-off bit 1 set when the safety loop turned output off.
// - Output-off bit 3 is external shutdown; bit 2 unused.
// - Protection bits 0, 1, 2 are overvoltage, undervoltage, overcurrent trips.
// - Protection bit 4 is mains failure; bit 3 unused.
// - Protection bit 5 is over-temperature; bit 6 unused.
// - Protection bit 7 is foldback, bit 8 fan failure.
// - Load-share bit 0 is master, bit 1 is follower.
// - Query answers are decimal values of the weighted bit sum.
// - Event and condition are queryable; enable and both filters writable and readable.
// - Operation-complete occupies bit 0 of the standard event register.
`timescale 1ns/10ps
module opsr_top
  import opsr_pkg::*;
#(
  parameter int unsigned W = OPSR_W
) (
  input  wire logic          ref_clk_i,
  input  wire logic          srst_i,
  // Command port from the message parser
  input  wire logic          cmd_valid_i,
  input  wire logic [3:0]    cmd_code_i,
  input  wire logic [1:0]    cmd_sel_i,
  input  wire logic [W-1:0]  cmd_data_i,
  output logic               cmd_ready_o,
  output logic               rsp_valid_o,
  output logic      [19:0]   rsp_bcd_o,
  // Pending-operation status from the supply controller
  input  wire logic          op_pending_i,
  output logic               std_event_opc_o,
  // Supply state
  input  wire logic          calibration_active_i,
  input  wire logic          local_lockout_i,
  input  wire logic          cv_mode_i,
  input  wire logic          cc_mode_i,
  input  wire logic          program_running_i,
  input  wire logic          safety_loop_open_i,
  input  wire logic          ext_shutdown_i,
  input  wire logic          overvoltage_trip_i,
  input  wire logic          undervoltage_trip_i,
  input  wire logic          overcurrent_trip_i,
  input  wire logic          mains_fail_trip_i,
  input  wire logic          overtemp_trip_i,
  input  wire logic          foldback_trip_i,
  input  wire logic          fan_fail_trip_i,
  input  wire logic          share_master_i,
  input  wire logic          share_follower_i,
  output logic               operation_summary_o
);

  typedef enum logic [1:0] {
    OPSR_IDLE,
    OPSR_WAIT_PEND,
    OPSR_CONVERT
  } opsr_state_e;

  opsr_state_e state;
  opsr_state_e next_state;
  logic        opc_armed;
  logic        next_opc_armed;
  logic        next_opc_flag;

  logic [W-1:0] cond   [4];
  logic [W-1:0] cond_q [4];
  logic [W-1:0] evt    [4];
  logic [W-1:0] ena    [4];
  logic [W-1:0] ptr    [4];
  logic [W-1:0] ntr    [4];
  logic [3:0]   summ;
  logic [3:0]   wr_ena_v;
  logic [3:0]   wr_ptr_v;
  logic [3:0]   wr_ntr_v;
  logic [3:0]   evt_rd_v;
  logic [W-1:0] q_value;
  logic         dec_start;
  logic         dec_busy;
  logic         dec_done;
  logic         accept;
  opsr_cmd_e    cmd;
  // Remembers whether the wait ends with a query answer of 1
  logic         cmd_is_q_q;
  logic         next_cmd_is_q;

  assign cmd = opsr_cmd_e'(cmd_code_i);

  // Condition vectors; several output-off causes can be set at once
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cond[i] = '0;
    end
    cond[0][OPER_CAL_BIT]   = calibration_active_i;
    cond[0][OPER_SHUT_BIT]  = summ[1];
    cond[0][OPER_LOCK_BIT]  = local_lockout_i;
    cond[0][OPER_SHARE_BIT] = summ[3];
    cond[0][OPER_CV_BIT]    = cv_mode_i;
    cond[0][OPER_CC_BIT]    = cc_mode_i;
    cond[0][OPER_PROG_BIT]  = program_running_i;
    cond[1][SHUT_PROT_BIT]  = summ[2];
    cond[1][SHUT_LOOP_BIT]  = safety_loop_open_i;
    cond[1][SHUT_EXT_BIT]   = ext_shutdown_i;
    cond[2][PROT_OV_BIT]    = overvoltage_trip_i;
    cond[2][PROT_UV_BIT]    = undervoltage_trip_i;
    cond[2][PROT_OC_BIT]    = overcurrent_trip_i;
    cond[2][PROT_MAINS_BIT] = mains_fail_trip_i;
    cond[2][PROT_OT_BIT]    = overtemp_trip_i;
    cond[2][PROT_FOLD_BIT]  = foldback_trip_i;
    cond[2][PROT_FAN_BIT]   = fan_fail_trip_i;
    // Master/follower is host-configured; both clear would be unpredictable
    cond[3][SHARE_MST_BIT]  = share_master_i;
    cond[3][SHARE_FOL_BIT]  = share_follower_i;
  end

  localparam logic [W-1:0] IMPL_TAB [4] = '{OPER_IMPL_MASK, SHUT_IMPL_MASK, PROT_IMPL_MASK, SHARE_IMPL_MASK};

  for (genvar g = 0; g < 4; g++) begin : g_reg
    opsr_reg #(
      .W    (W),
      .IMPL (IMPL_TAB[g])
    ) u_reg (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .cond_i      (cond[g]),
      .wr_data_i   (cmd_data_i),
      .wr_enable_i (wr_ena_v[g]),
      .wr_ptr_i    (wr_ptr_v[g]),
      .wr_ntr_i    (wr_ntr_v[g]),
      .evt_read_i  (evt_rd_v[g]),
      .cond_o      (cond_q[g]),
      .event_o     (evt[g]),
      .enable_o    (ena[g]),
      .ptr_o       (ptr[g]),
      .ntr_o       (ntr[g]),
      .summary_o   (summ[g])
    );
  end

  assign operation_summary_o = summ[0];

  // Commands are taken only in idle; a pending wait keeps ready low
  assign cmd_ready_o = (state == OPSR_IDLE);
  assign accept      = cmd_valid_i && cmd_ready_o;

  always_comb begin
    wr_ena_v = 4'h0;
    wr_ptr_v = 4'h0;
    wr_ntr_v = 4'h0;
    evt_rd_v = 4'h0;
    if (accept) begin
      wr_ena_v[cmd_sel_i] = (cmd == OPSR_CMD_W_ENABLE);
      wr_ptr_v[cmd_sel_i] = (cmd == OPSR_CMD_W_PTR);
      wr_ntr_v[cmd_sel_i] = (cmd == OPSR_CMD_W_NTR);
      evt_rd_v[cmd_sel_i] = (cmd == OPSR_CMD_Q_EVENT);
    end
  end

  always_comb begin
    q_value = '0;
    unique case (cmd)
      OPSR_CMD_Q_EVENT:  q_value = evt[cmd_sel_i];
      OPSR_CMD_Q_COND:   q_value = cond_q[cmd_sel_i];
      OPSR_CMD_Q_ENABLE: q_value = ena[cmd_sel_i];
      OPSR_CMD_Q_PTR:    q_value = ptr[cmd_sel_i];
      OPSR_CMD_Q_NTR:    q_value = ntr[cmd_sel_i];
      OPSR_CMD_OPC_Q:    q_value = W'(1);
      default:           q_value = '0;
    endcase
  end

  assign dec_start = accept && (cmd inside {OPSR_CMD_Q_EVENT, OPSR_CMD_Q_COND, OPSR_CMD_Q_ENABLE,
                                            OPSR_CMD_Q_PTR, OPSR_CMD_Q_NTR});

  opsr_dec u_dec (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .start_i   (dec_start || (state == OPSR_WAIT_PEND && opc_armed && !op_pending_i && cmd_is_q_q)),
    .value_i   (dec_start ? q_value : W'(1)),
    .busy_o    (dec_busy),
    .done_o    (dec_done),
    .bcd_o     (rsp_bcd_o)
  );

  always_comb begin
    next_state     = state;
    next_opc_armed = opc_armed;
    next_cmd_is_q  = cmd_is_q_q;
    next_opc_flag  = std_event_opc_o;
    unique case (state)
      OPSR_IDLE: begin
        if (dec_start) begin
          next_state = OPSR_CONVERT;
        end else if (accept && cmd inside {OPSR_CMD_OPC, OPSR_CMD_OPC_Q, OPSR_CMD_WAI}) begin
          next_state     = OPSR_WAIT_PEND;
          next_opc_armed = (cmd != OPSR_CMD_WAI);
          next_cmd_is_q  = (cmd == OPSR_CMD_OPC_Q);
        end
      end
      OPSR_WAIT_PEND: begin
        if (!op_pending_i) begin
          if (opc_armed) begin
            next_opc_flag = 1'b1;
          end
          next_opc_armed = 1'b0;
          next_state     = cmd_is_q_q ? OPSR_CONVERT : OPSR_IDLE;
        end
      end
      OPSR_CONVERT: begin
        if (dec_done) begin
          next_state = OPSR_IDLE;
        end
      end
    endcase
    // Standard event read lives outside; it clears the flag via a fresh operation-complete only
    if (accept && cmd == OPSR_CMD_OPC) begin
      next_opc_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state           <= OPSR_IDLE;
      opc_armed       <= 1'b0;
      cmd_is_q_q      <= 1'b0;
      std_event_opc_o <= 1'b0;
      rsp_valid_o     <= 1'b0;
    end else begin
      state           <= next_state;
      opc_armed       <= next_opc_armed;
      cmd_is_q_q      <= next_cmd_is_q;
      std_event_opc_o <= next_opc_flag;
      rsp_valid_o     <= dec_done;
    end
  end

  a_wait_holds_ready: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == OPSR_WAIT_PEND && op_pending_i) |-> !cmd_ready_o ##1 !cmd_ready_o)
    else $error("command taken while an operation is pending");

  a_opc_sets_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == OPSR_WAIT_PEND && opc_armed && !op_pending_i) |=> std_event_opc_o)
    else $error("operation-complete flag not set after pending cleared");

  a_shut_summary: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[0][OPER_SHUT_BIT] == $past(summ[1])))
    else $error("operation bit 9 does not follow output-off summary");

  a_share_summary: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[0][OPER_SHARE_BIT] == $past(summ[3])))
    else $error("operation bit 11 does not follow load-share summary");

  a_prot_summary: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[1][SHUT_PROT_BIT] == $past(|(evt[2] & ena[2]))))
    else $error("output-off bit 0 does not follow protection summary");

  a_cal_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[0][OPER_CAL_BIT] == $past(calibration_active_i)))
    else $error("calibration bit does not follow input");

  a_resp_after_query: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    dec_start |-> ##[6:8] rsp_valid_o)
    else $error("query answer not delivered in time");

  a_mains_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[2][PROT_MAINS_BIT] == $past(mains_fail_trip_i)))
    else $error("mains failure bit does not follow input");

  a_cv_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[0][OPER_CV_BIT] == $past(cv_mode_i)))
    else $error("constant-voltage bit does not follow input");

  a_prog_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[0][OPER_PROG_BIT] == $past(program_running_i)))
    else $error("program running bit does not follow input");

  a_loop_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[1][SHUT_LOOP_BIT] == $past(safety_loop_open_i)))
    else $error("safety loop bit does not follow input");

  a_fan_cond: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 (cond_q[2][PROT_FAN_BIT] == $past(fan_fail_trip_i)))
    else $error("fan failure bit does not follow input");

  // Query form answers only once the pending work is done
  sequence s_opcq_release;
    state == OPSR_WAIT_PEND && opc_armed && cmd_is_q_q && !op_pending_i;
  endsequence

  a_opcq_answer: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_opcq_release |-> ##7 rsp_valid_o)
    else $error("operation-complete query not answered after pending cleared");

endmodule : opsr_top

// File: opsr_host.sv
// Remote host model: issues one command at a time and decodes decimal answers
`timescale 1ns/10ps
module opsr_host
  import opsr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        cmd_ready_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [19:0] rsp_bcd_i,
  output logic             cmd_valid_o,
  output logic      [3:0]  cmd_code_o,
  output logic      [1:0]  cmd_sel_o,
  output logic      [15:0] cmd_data_o,
  output logic             share_master_o,
  output logic             share_follower_o
);
  initial begin
    cmd_valid_o      = 1'b0;
    cmd_code_o       = 4'h0;
    cmd_sel_o        = 2'h0;
    cmd_data_o       = 16'h0000;
    share_master_o   = 1'b1;
    share_follower_o = 1'b0;
  end

  task automatic set_share(input logic m, input logic f);
    @(negedge ref_clk_i);
    share_master_o   = m;
    share_follower_o = f;
  endtask : set_share

  // One command per call; queries wait for and decode the decimal answer
  task automatic xfer(input opsr_cmd_e code, input logic [1:0] sel, input logic [15:0] data,
                      output logic [19:0] val);
    int   n;
    logic want;
    want = code inside {OPSR_CMD_Q_EVENT, OPSR_CMD_Q_COND, OPSR_CMD_Q_ENABLE, OPSR_CMD_Q_PTR,
                        OPSR_CMD_Q_NTR, OPSR_CMD_OPC_Q};
    val  = 'x;
    // Random think time so the device sees prompt and slow hosts
    repeat ($urandom_range(2, 1)) @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_sel_o   = sel;
    cmd_data_o  = data;
    n = 0;
    while (cmd_ready_i !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    // Released fields must not keep looking valid
    cmd_valid_o = 1'b0;
    cmd_sel_o   = ~sel;
    cmd_data_o  = ~data;
    if (want) begin
      n = 0;
      while (rsp_valid_i !== 1'b1 && n < 40) begin
        @(negedge ref_clk_i);
        n++;
      end
      if (rsp_valid_i === 1'b1) begin
        val = 20'((rsp_bcd_i[19:16] * 10000) + (rsp_bcd_i[15:12] * 1000) + (rsp_bcd_i[11:8] * 100) +
                  (rsp_bcd_i[7:4] * 10) + rsp_bcd_i[3:0]);
      end
    end
  endtask : xfer
endmodule : opsr_host

// File: opsr_top_tb.sv
// Self-checking bench for the operation status register tree
`timescale 1ns/10ps
module opsr_top_tb
  import opsr_pkg::*;
;
  logic        ref_clk_i;
  logic        srst_i;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        op_pending;
  logic        opc;
  logic        summ;
  logic        sh_m;
  logic        sh_f;
  logic [3:0]  cmd_code;
  logic [1:0]  cmd_sel;
  logic [15:0] cmd_data;
  logic [19:0] bcd;
  logic [19:0] v;
  logic [15:0] d;
  logic [13:0] st;
  int          fails;
  int          total_checks;
  int          cyc;
  logic [15:0] impl [4] = '{OPER_IMPL_MASK, SHUT_IMPL_MASK, PROT_IMPL_MASK, SHARE_IMPL_MASK};
  opsr_cmd_e   wc [3] = '{OPSR_CMD_W_ENABLE, OPSR_CMD_W_PTR, OPSR_CMD_W_NTR};
  opsr_cmd_e   rc [3] = '{OPSR_CMD_Q_ENABLE, OPSR_CMD_Q_PTR, OPSR_CMD_Q_NTR};

  opsr_top u_opsr_top (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .cmd_sel_i(cmd_sel), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_bcd_o(bcd), .op_pending_i(op_pending), .std_event_opc_o(opc),
    .calibration_active_i(st[0]), .local_lockout_i(st[1]), .cv_mode_i(st[2]), .cc_mode_i(st[3]),
    .program_running_i(st[4]), .safety_loop_open_i(st[5]), .ext_shutdown_i(st[6]),
    .overvoltage_trip_i(st[7]), .undervoltage_trip_i(st[8]), .overcurrent_trip_i(st[9]),
    .mains_fail_trip_i(st[10]), .overtemp_trip_i(st[11]), .foldback_trip_i(st[12]),
    .fan_fail_trip_i(st[13]), .share_master_i(sh_m), .share_follower_i(sh_f),
    .operation_summary_o(summ)
  );

  opsr_host u_opsr_host (
    .ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid), .rsp_bcd_i(bcd),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_sel_o(cmd_sel), .cmd_data_o(cmd_data),
    .share_master_o(sh_m), .share_follower_o(sh_f)
  );

  function automatic logic [15:0] exp_prot(input logic [13:0] s);
    return {7'h00, s[13], s[12], 1'b0, s[11], s[10], 1'b0, s[9], s[8], s[7]};
  endfunction : exp_prot

  function automatic logic [15:0] exp_oper(input logic [13:0] s);
    return {1'b0, s[4], s[3], s[2], 1'b0, s[1], 1'b0, 8'h00, s[0]};
  endfunction : exp_oper

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({19'h00000, got}, {19'h00000, exp});
  endtask : chk1

  task automatic q(input opsr_cmd_e c, input logic [1:0] s, input logic [15:0] dt, input logic [19:0] e);
    u_opsr_host.xfer(c, s, dt, v);
    chk(v, e);
  endtask : q

  task automatic w(input opsr_cmd_e c, input logic [1:0] s, input logic [15:0] dt);
    u_opsr_host.xfer(c, s, dt, v);
  endtask : w

  task automatic summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Whole run needs under a thousand cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    srst_i     = 1'b1;
    op_pending = 1'b0;
    st         = '0;
    void'($urandom(7209));
    repeat (3) @(negedge ref_clk_i);
    srst_i = 1'b0;
    for (int s = 0; s < 4; s++) begin
      q(OPSR_CMD_Q_ENABLE, 2'(s), 16'h0000, 20'(OPSR_ENA_RST));
      q(OPSR_CMD_Q_PTR, 2'(s), 16'h0000, 20'(OPSR_PTR_RST));
      q(OPSR_CMD_Q_NTR, 2'(s), 16'h0000, 20'(OPSR_NTR_RST));
    end
    // Enables are still zero, so every summary stays low here
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk_i);
      st = (i == 0) ? 14'h3FFF : 14'($urandom);
      repeat (3) @(negedge ref_clk_i);
      q(OPSR_CMD_Q_COND, OPSR_SEL_PROT, 16'h0000, 20'(exp_prot(st)));
      q(OPSR_CMD_Q_COND, OPSR_SEL_SHUT, 16'h0000, {16'h0000, st[6], 1'b0, st[5], 1'b0});
      q(OPSR_CMD_Q_COND, OPSR_SEL_OPER, 16'h0000, 20'(exp_oper(st)));
      q(OPSR_CMD_Q_COND, OPSR_SEL_SHARE, 16'h0000, 20'h00001);
      chk1(summ, 1'b0);
    end
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom) & impl[i / 3];
      w(wc[i % 3], 2'(i / 3), d);
      q(rc[i % 3], 2'(i / 3), 16'h0000, 20'(d));
    end
    @(negedge ref_clk_i);
    st = '0;
    for (int s = 0; s < 4; s++) begin
      w(OPSR_CMD_W_PTR, 2'(s), 16'hFFFF);
      w(OPSR_CMD_W_NTR, 2'(s), 16'h0000);
      w(OPSR_CMD_W_ENABLE, 2'(s), impl[s]);
    end
    // Clear leaves first so no parent sees a fresh rise
    for (int s = 3; s >= 0; s--) begin
      w(OPSR_CMD_Q_EVENT, 2'(s), 16'h0000);
    end
    chk1(summ, 1'b0);
    @(negedge ref_clk_i);
    st = 14'h0080;
    u_opsr_host.set_share(1'b0, 1'b1);
    repeat (10) @(negedge ref_clk_i);
    chk1(summ, 1'b1);
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_PROT, 16'h0000, 20'h00001);
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_PROT, 16'h0000, 20'h00000);
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_SHUT, 16'h0000, 20'h00001);
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_SHARE, 16'h0000, 20'h00002);
    // Weights 512 and 2048 together: decimal 2560
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_OPER, 16'h0000, 20'h00A00);
    w(OPSR_CMD_W_NTR, OPSR_SEL_PROT, 16'h0001);
    @(negedge ref_clk_i);
    st = '0;
    repeat (4) @(negedge ref_clk_i);
    q(OPSR_CMD_Q_EVENT, OPSR_SEL_PROT, 16'h0000, 20'h00001);
    u_opsr_host.set_share(1'b1, 1'b0);
    op_pending = 1'b1;
    w(OPSR_CMD_OPC, OPSR_SEL_OPER, 16'h0000);
    repeat (6) @(negedge ref_clk_i);
    chk1(opc, 1'b0);
    op_pending = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk1(opc, 1'b1);
    op_pending = 1'b1;
    fork
      begin
        repeat (5) @(negedge ref_clk_i);
        op_pending = 1'b0;
      end
    join_none
    q(OPSR_CMD_OPC_Q, OPSR_SEL_OPER, 16'h0000, 20'h00001);
    @(negedge ref_clk_i);
    op_pending = 1'b1;
    w(OPSR_CMD_WAI, OPSR_SEL_OPER, 16'h0000);
    repeat (5) @(negedge ref_clk_i);
    chk1(cmd_ready, 1'b0);
    op_pending = 1'b0;
    q(OPSR_CMD_Q_COND, OPSR_SEL_SHARE, 16'h0000, 20'h00001);
    summarize();
  end
endmodule : opsr_top_tb
